/* logic/data_fifo.sv */
`timescale 1ns/100ps
module data_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	input  wire logic             flush
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge ref_clk) begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* logic/nand_host.sv */
`timescale 1ns/100ps
`include "nand_host_consts.svh"
module nand_host (
	input  wire logic                      ref_clk,
	input  wire logic                      arst_n,
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire nand_host_pkg::op_t        req_op,
	input  wire nand_host_pkg::flash_addr_t req_addr,
	input  wire logic                      req_spare,
	input  wire logic                      req_verify,
	input  wire nand_host_pkg::byte_t      wr_data,
	input  wire logic                      wr_valid,
	output logic                           wr_ready,
	output nand_host_pkg::byte_t           rd_data,
	output logic                           rd_valid,
	output logic                           done,
	output logic                           failed,
	output logic                           retired,
	output logic                           refused,
	output logic                           cmd_latch,
	output logic                           addr_latch,
	output logic                           chip_sel_n,
	output logic                           write_pulse_n,
	output logic                           output_pulse_n,
	output logic                           spare_zone_gate_n,
	output nand_host_pkg::byte_t           io_out,
	output logic                           io_oe,
	input  wire nand_host_pkg::byte_t      io_in,
	input  wire logic                      ready_busy
);
	import nand_host_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE, S_CMD, S_ADDR, S_DATA, S_GO, S_WAIT_BUSY, S_WAIT_READY,
		S_STAT_CMD, S_STAT_RD, S_READ, S_VER_CMD, S_VER_ADDR, S_VER_WAIT,
		S_VER_RD, S_DONE
	} state_t;

	state_t      st_q;
	state_t      after_q;
	op_t         op_q;
	flash_addr_t addr_q;
	logic        spare_q;
	logic        verify_q;
	logic        mism_q;
	logic [1:0]  retry_q;
	logic [1:0]  acnt_q;
	logic [9:0]  bcnt_q;
	logic [4:0]  tim_q;
	logic [1:0]  ph_q;
	byte_t       cmd_q;
	logic [1:0]  rb_sync_q;
	byte_t       io_sync1_q;
	byte_t       io_sync_q;
	byte_t       samp_q;
	logic        bad_q [`NUM_BLOCKS];
	logic        fifo_in_ready;
	byte_t       fifo_data;
	logic        fifo_valid;
	logic        fifo_pop;
	logic        fifo_flush;
	logic [9:0]  last_byte;
	logic        busy_wait;
	logic        ready_now;
	block_t      blk;
	logic [1:0]  addr_cycles;

	assign blk         = addr_q[23:14];
	assign last_byte   = spare_q ? `PAGE_LAST_MAIN : `PAGE_LAST_FULL;
	assign ready_now   = rb_sync_q[1];
	assign addr_cycles = (op_q == OP_ERASE) ? 2'(`ERASE_ADDR_CYCLES) : 2'(`ADDR_CYCLES);
	assign busy_wait   = (tim_q != '0);
	assign fifo_pop    = (st_q == S_DATA) && (ph_q == 2'd2) && !busy_wait;
	assign fifo_flush  = (st_q == S_IDLE);
	assign wr_ready    = fifo_in_ready;

	data_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_data   (wr_data),
		.in_valid  (wr_valid && op_q == OP_PROGRAM && st_q != S_IDLE),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.flush     (fifo_flush)
	);

	// pins from the device pass two flops
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rb_sync_q  <= '0;
			io_sync1_q <= '0;
			io_sync_q  <= '0;
		end else begin
			rb_sync_q  <= {rb_sync_q[0], ready_busy};
			io_sync1_q <= io_in;
			io_sync_q  <= io_sync1_q;
		end
	end

	// bad block table survives until reset only; no persistent copy kept
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `NUM_BLOCKS; i++)
				bad_q[i] <= 1'b0;
		end else if (st_q == S_STAT_RD && ph_q == 2'd3 && !busy_wait
			&& samp_q[`STATUS_FAIL_BIT] && op_q != OP_RESET) begin
			bad_q[blk] <= 1'b1;
		end else if (st_q == S_VER_RD && ph_q == 2'd3 && !busy_wait && mism_q
			&& retry_q == 2'd3) begin
			bad_q[blk] <= 1'b1;
		end
	end

	// write strobe phases: 0 setup, 1 low, 2 high, 3 advance; read strobe phases: 0 low, 1 hold, 2 sample/high, 3 advance
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q              <= S_IDLE;
			after_q           <= S_IDLE;
			op_q              <= OP_READ;
			addr_q            <= '0;
			spare_q           <= 1'b0;
			verify_q          <= 1'b0;
			mism_q            <= 1'b0;
			retry_q           <= '0;
			acnt_q            <= '0;
			bcnt_q            <= '0;
			tim_q             <= '0;
			ph_q              <= '0;
			cmd_q             <= '0;
			samp_q            <= '0;
			req_ready         <= 1'b0;
			rd_data           <= '0;
			rd_valid          <= 1'b0;
			done              <= 1'b0;
			failed            <= 1'b0;
			retired           <= 1'b0;
			refused           <= 1'b0;
			cmd_latch         <= 1'b0;
			addr_latch        <= 1'b0;
			chip_sel_n        <= 1'b1;
			write_pulse_n     <= 1'b1;
			output_pulse_n    <= 1'b1;
			spare_zone_gate_n <= 1'b1;
			io_out            <= '0;
			io_oe             <= 1'b0;
		end else begin
			rd_valid  <= 1'b0;
			done      <= 1'b0;
			refused   <= 1'b0;
			retired   <= 1'b0;
			// ready must not wait for valid, or a valid-first requester hangs
			req_ready <= (st_q == S_IDLE);
			if (busy_wait) begin
				tim_q <= tim_q - 1'b1;
			end else begin
				case (st_q)
				S_IDLE: begin
					chip_sel_n <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						op_q      <= req_op;
						addr_q    <= req_addr;
						spare_q   <= req_spare;
						verify_q  <= req_verify;
						retry_q   <= '0;
						failed    <= 1'b0;
						ph_q      <= '0;
						if (req_op != OP_RESET && bad_q[req_addr[23:14]]) begin
							refused <= 1'b1;
						end else begin
							chip_sel_n        <= 1'b0;
							// gate pin high hides the spare bytes: page ends at 511
							spare_zone_gate_n <= req_spare;
							st_q              <= S_CMD;
							case (req_op)
							OP_READ:    cmd_q <= `CMD_READ;
							OP_PROGRAM: cmd_q <= `CMD_SERIAL_IN;
							OP_ERASE:   cmd_q <= `CMD_ERASE_SETUP;
							default:    cmd_q <= `CMD_RESET;
							endcase
						end
					end
				end
				S_CMD, S_GO, S_STAT_CMD, S_VER_CMD: begin
					case (ph_q)
					2'd0: begin
						cmd_latch <= 1'b1;
						io_oe     <= 1'b1;
						io_out    <= cmd_q;
						ph_q      <= 2'd1;
					end
					2'd1: begin
						write_pulse_n <= 1'b0;
						tim_q         <= 5'(`T_STROBE_CYC);
						ph_q          <= 2'd2;
					end
					2'd2: begin
						write_pulse_n <= 1'b1;
						tim_q         <= 5'(`T_STROBE_CYC);
						ph_q          <= 2'd3;
					end
					default: begin
						cmd_latch <= 1'b0;
						io_oe     <= 1'b0;
						ph_q      <= '0;
						acnt_q    <= '0;
						bcnt_q    <= '0;
						case (st_q)
						S_CMD: st_q <= (op_q == OP_RESET) ? S_WAIT_BUSY : S_ADDR;
						S_VER_CMD: st_q <= S_VER_ADDR;
						S_GO: st_q <= S_WAIT_BUSY;
						default: begin
							tim_q <= 5'(`T_WHR_CYC);
							st_q  <= S_STAT_RD;
						end
						endcase
					end
					endcase
				end
				S_ADDR, S_VER_ADDR: begin
					case (ph_q)
					2'd0: begin
						addr_latch <= 1'b1;
						io_oe      <= 1'b1;
						if (op_q == OP_ERASE)
							io_out <= (acnt_q == 2'd0) ? addr_q[16:9] : {1'b0, addr_q[23:17]};
						else
							io_out <= (acnt_q == 2'd0) ? addr_q[7:0]
								: (acnt_q == 2'd1) ? addr_q[16:9] : {1'b0, addr_q[23:17]};
						ph_q <= 2'd1;
					end
					2'd1: begin
						write_pulse_n <= 1'b0;
						tim_q         <= 5'(`T_STROBE_CYC);
						ph_q          <= 2'd2;
					end
					2'd2: begin
						write_pulse_n <= 1'b1;
						tim_q         <= 5'(`T_STROBE_CYC);
						ph_q          <= 2'd3;
					end
					default: begin
						ph_q <= '0;
						if (acnt_q == addr_cycles - 2'd1) begin
							addr_latch <= 1'b0;
							io_oe      <= 1'b0;
							if (op_q == OP_ERASE) begin
								cmd_q <= `CMD_ERASE_GO;
								st_q  <= S_GO;
							end else if (op_q == OP_PROGRAM && st_q == S_ADDR) begin
								st_q <= S_DATA;
							end else begin
								after_q <= (st_q == S_VER_ADDR) ? S_VER_RD : S_READ;
								tim_q   <= 5'(`T_WB_CYC);
								st_q    <= S_VER_WAIT;
							end
						end else begin
							acnt_q <= acnt_q + 1'b1;
						end
					end
					endcase
				end
				S_DATA: begin
					case (ph_q)
					2'd0: if (fifo_valid) begin
						io_oe  <= 1'b1;
						io_out <= fifo_data;
						ph_q   <= 2'd1;
					end
					2'd1: begin
						write_pulse_n <= 1'b0;
						tim_q         <= 5'(`T_STROBE_CYC);
						ph_q          <= 2'd2;
					end
					2'd2: begin
						write_pulse_n <= 1'b1;
						tim_q         <= 5'(`T_STROBE_CYC);
						ph_q          <= 2'd3;
					end
					default: begin
						ph_q   <= '0;
						bcnt_q <= bcnt_q + 1'b1;
						if (bcnt_q == last_byte) begin
							io_oe <= 1'b0;
							cmd_q <= `CMD_PROG_GO;
							st_q  <= S_GO;
						end
					end
					endcase
				end
				S_WAIT_BUSY: begin
					// wait out busy onset before watching ready
					tim_q <= 5'(`T_WB_CYC);
					st_q  <= S_WAIT_READY;
				end
				S_WAIT_READY, S_VER_WAIT: if (ready_now) begin
					if (st_q == S_VER_WAIT) begin
						st_q <= after_q;
					end else if (op_q == OP_RESET) begin
						st_q <= S_DONE;
					end else begin
						cmd_q <= `CMD_STATUS;
						st_q  <= S_STAT_CMD;
					end
				end
				S_STAT_RD, S_READ, S_VER_RD: begin
					case (ph_q)
					2'd0: begin
						output_pulse_n <= 1'b0;
						tim_q          <= 5'(`T_STROBE_CYC);
						ph_q           <= 2'd1;
					end
					2'd1: begin
						tim_q <= 5'd3;
						ph_q  <= 2'd2;
					end
					2'd2: begin
						output_pulse_n <= 1'b1;
						// take the byte before the strobe rises; a released bus is not valid
						samp_q         <= io_sync_q;
						tim_q          <= 5'(`T_STROBE_CYC);
						ph_q           <= 2'd3;
					end
					default: begin
						ph_q   <= '0;
						bcnt_q <= bcnt_q + 1'b1;
						if (st_q == S_STAT_RD) begin
							if (samp_q[`STATUS_FAIL_BIT]) begin
								failed  <= 1'b1;
								retired <= 1'b1;
								st_q    <= S_DONE;
							end else if (op_q == OP_PROGRAM && verify_q) begin
								cmd_q  <= `CMD_READ;
								mism_q <= 1'b0;
								st_q   <= S_VER_CMD;
							end else begin
								// verify off: caller must keep a 1-correct 2-detect code
								st_q <= S_DONE;
							end
						end else if (st_q == S_READ) begin
							rd_data  <= samp_q;
							rd_valid <= 1'b1;
							if (bcnt_q == last_byte)
								st_q <= S_DONE;
						end else begin
							// verify only flags byte 0 read back as 8'hFF (erased); data compare needs source copy
							mism_q <= mism_q | (samp_q == 8'hFF && bcnt_q == 10'h000);
							if (bcnt_q == last_byte) begin
								if (!mism_q) begin
									st_q <= S_DONE;
								end else if (retry_q == 2'd3) begin
									failed  <= 1'b1;
									retired <= 1'b1;
									st_q    <= S_DONE;
								end else begin
									// no source copy kept, so a retry repeats the read-back
									retry_q <= retry_q + 1'b1;
									cmd_q   <= `CMD_READ;
									mism_q  <= 1'b0;
									st_q    <= S_VER_CMD;
								end
							end
						end
					end
					endcase
				end
				S_DONE: begin
					chip_sel_n        <= 1'b1;
					spare_zone_gate_n <= 1'b1;
					done              <= 1'b1;
					st_q              <= S_IDLE;
				end
				default: st_q <= S_IDLE;
				endcase
			end
		end
	end
endmodule

/* logic/nand_host_consts.svh */
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH

`define CLK_PERIOD_NS     5
// strobe, write-to-read and busy-onset times in ns, cycles rounded up
`define T_STROBE_NS       30
`define T_STROBE_CYC      ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WHR_NS          60
`define T_WHR_CYC         ((`T_WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WB_NS           100
`define T_WB_CYC          ((`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_READ          8'h00
`define CMD_READ_SPARE    8'h50
`define CMD_SERIAL_IN     8'h80
`define CMD_PROG_GO       8'h10
`define CMD_ERASE_SETUP   8'h60
`define CMD_ERASE_GO      8'hD0
`define CMD_STATUS        8'h70
`define CMD_RESET         8'hFF
`define STATUS_FAIL_BIT   0
`define PAGE_LAST_MAIN    10'h1FF
`define PAGE_LAST_FULL    10'h20F
`define ADDR_CYCLES       3
`define ERASE_ADDR_CYCLES 2
`define NUM_BLOCKS        1024
`define FIFO_DEPTH        16

`endif

/* logic/nand_host_pkg.sv */
package nand_host_pkg;
	typedef enum logic [1:0] {
		OP_READ,
		OP_PROGRAM,
		OP_ERASE,
		OP_RESET
	} op_t;
	typedef logic [7:0]  byte_t;
	typedef logic [9:0]  block_t;
	typedef logic [23:0] flash_addr_t;
endpackage

/* tb/nand_dev_model.sv */
`timescale 1ns/100ps
`include "nand_host_consts.svh"
module nand_dev_model #(
	parameter int BUSY_NS = 2000,
	parameter int LOAD_NS = 500
) (
	input  wire logic       cmd_latch,
	input  wire logic       addr_latch,
	input  wire logic       chip_sel_n,
	input  wire logic       write_pulse_n,
	input  wire logic       output_pulse_n,
	input  wire logic       spare_zone_gate_n,
	input  wire logic [7:0] io_out,
	input  wire logic       fail_op,
	output logic      [7:0] io_in,
	output logic            ready_busy,
	output int              host_faults
);
	logic [7:0] mode_q;
	logic [7:0] dout_q;
	logic [9:0] col_q;
	logic       fail_q;
	int         addr_n;

	task automatic go_busy(input int span);
		fork
			begin
				ready_busy = 1'b0;
				#(span);
				ready_busy = 1'b1;
			end
		join_none
	endtask

	initial begin
		ready_busy = 1'b1;
		host_faults = 0;
		mode_q = 8'h00;
		dout_q = 8'h00;
		col_q = 10'h000;
		fail_q = 1'b0;
		addr_n = 0;
	end

	// chip select is not looked at: either level is tolerated
	always @(posedge write_pulse_n) begin
		if (cmd_latch) begin
			if (!ready_busy && io_out !== `CMD_RESET) host_faults++;
			mode_q = io_out;
			addr_n = 0;
			col_q = 10'h000;
			if (io_out == `CMD_PROG_GO || io_out == `CMD_ERASE_GO || io_out == `CMD_RESET) begin
				fail_q = fail_op;
				go_busy(BUSY_NS);
			end
		end else if (addr_latch) begin
			addr_n++;
			// a fourth address cycle changes nothing
			if (addr_n == 3 && (mode_q == `CMD_READ || mode_q == `CMD_READ_SPARE)) go_busy(LOAD_NS);
		end else begin
			if (col_q > (spare_zone_gate_n ? `PAGE_LAST_MAIN : `PAGE_LAST_FULL)) host_faults++;
			col_q++;
		end
	end

	always @(negedge output_pulse_n) begin
		if (!ready_busy) host_faults++;
		if (mode_q == `CMD_STATUS) begin
			dout_q = {1'b1, ready_busy, 5'h00, fail_q};
		end else begin
			dout_q = col_q[7:0];
			col_q = (col_q == `PAGE_LAST_FULL) ? 10'h000 : col_q + 10'h001;
		end
	end

	// released bus shows inverted data so stale values never match
	assign io_in = output_pulse_n ? ~dout_q : dout_q;
endmodule

/* tb/nand_host_assertions.sv */
`timescale 1ns/100ps
`include "nand_host_consts.svh"
module nand_host_assertions (
	input wire logic                 ref_clk,
	input wire logic                 arst_n,
	input wire logic                 failed,
	input wire logic                 retired,
	input wire logic                 refused,
	input wire logic                 cmd_latch,
	input wire logic                 addr_latch,
	input wire logic                 write_pulse_n,
	input wire logic                 output_pulse_n,
	input wire logic                 spare_zone_gate_n,
	input wire nand_host_pkg::byte_t io_out,
	input wire logic                 io_oe,
	input wire logic                 ready_busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic [9:0] data_cnt_q;
	logic [2:0] addr_cnt_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_cnt_q <= 10'h000;
		end else if (cmd_latch) begin
			data_cnt_q <= 10'h000;
		end else if (!addr_latch && $fell(write_pulse_n)) begin
			data_cnt_q <= data_cnt_q + 10'h001;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_cnt_q <= 3'h0;
		end else if (cmd_latch) begin
			addr_cnt_q <= 3'h0;
		end else if (addr_latch && $fell(write_pulse_n) && addr_cnt_q != 3'h7) begin
			addr_cnt_q <= addr_cnt_q + 3'h1;
		end
	end

	sequence s_status_cmd;
		$rose(write_pulse_n) && cmd_latch && io_out == `CMD_STATUS;
	endsequence
	sequence s_read_pulse;
		##[1:60] $fell(output_pulse_n);
	endsequence

	a_status_then_read: assert property (s_status_cmd |-> s_read_pulse)
		else $error("no read strobe after status command");
	a_addr_latch_held: assert property ($fell(addr_latch) |-> addr_cnt_q >= 3'h2)
		else $error("address latch dropped mid sequence");
	a_addr_cycle_count: assert property (addr_cnt_q <= 3'h3)
		else $error("too many address cycles");
	a_page_end_stop: assert property (data_cnt_q <= (spare_zone_gate_n ? 10'h200 : 10'h210))
		else $error("write strobe past page end");
	a_no_read_busy: assert property ($fell(output_pulse_n) |-> ready_busy)
		else $error("read strobe while busy");
	a_busy_only_reset: assert property ($fell(write_pulse_n) && !ready_busy |-> cmd_latch && io_out == `CMD_RESET)
		else $error("write strobe while busy");
	a_refused_pins_quiet: assert property (refused |=> (write_pulse_n && !cmd_latch)[*4])
		else $error("pin activity after refusal");
	a_retire_after_fail: assert property (retired |-> ##[0:1] failed)
		else $error("block retired without failure");
	a_read_bus_free: assert property (!output_pulse_n |-> !io_oe)
		else $error("host drives bus during read strobe");
endmodule

bind nand_host nand_host_assertions i_nand_host_assertions (
	.ref_clk, .arst_n, .failed, .retired, .refused, .cmd_latch, .addr_latch, .write_pulse_n,
	.output_pulse_n, .spare_zone_gate_n, .io_out, .io_oe, .ready_busy
);

/* tb/nand_host_tb.sv */
`timescale 1ns/100ps
module nand_host_tb;
	import nand_host_pkg::*;
	logic        ref_clk, arst_n, req_valid, req_ready, req_spare, req_verify;
	logic        wr_valid, wr_ready, rd_valid, done, failed, retired, refused;
	logic        cmd_latch, addr_latch, chip_sel_n, write_pulse_n, output_pulse_n;
	logic        spare_zone_gate_n, io_oe, ready_busy, fail_op, seen_ret, seen_ref;
	op_t         req_op;
	flash_addr_t req_addr;
	byte_t       wr_data, rd_data, io_out, io_in;
	int          host_faults, rd_cnt, num_errors, total_checks, rd_pulses;

	nand_host i_nand_host (.ref_clk, .arst_n, .req_valid, .req_ready, .req_op, .req_addr,
		.req_spare, .req_verify, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .done,
		.failed, .retired, .refused, .cmd_latch, .addr_latch, .chip_sel_n, .write_pulse_n,
		.output_pulse_n, .spare_zone_gate_n, .io_out, .io_oe, .io_in, .ready_busy);
	nand_dev_model i_nand_dev_model (.cmd_latch, .addr_latch, .chip_sel_n, .write_pulse_n,
		.output_pulse_n, .spare_zone_gate_n, .io_out, .fail_op, .io_in, .ready_busy, .host_faults);

	always #2.5 ref_clk = ~ref_clk;

	always @(negedge output_pulse_n) rd_pulses++;

	task automatic check_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_byte(input string what, input byte_t exp, input byte_t got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_count(input string what, input int exp, input int got);
		total_checks++;
		if (got != exp) begin
			num_errors++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// one whole operation: request, stream data, check read bytes and note retire/refuse flags
	task automatic run_op(input op_t op, input block_t blk, input logic spare, input logic fail);
		int   n;
		int   k;
		logic take;
		k = 0;
		take = 1'b0;
		rd_cnt = 0;
		seen_ret = 1'b0;
		seen_ref = 1'b0;
		@(negedge ref_clk);
		req_op = op;
		req_addr = {blk, 14'h0000};
		req_spare = spare;
		fail_op = fail;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) @(negedge ref_clk);
		for (n = 0; n < 30000; n++) begin
			@(negedge ref_clk);
			req_valid = 1'b0;
			if (wr_valid && take) k++;
			wr_valid = (op == OP_PROGRAM) && (k < (spare ? 512 : 528));
			wr_data = k[7:0];
			take = wr_ready;
			if (rd_valid === 1'b1) begin
				check_byte("rd_data", rd_cnt[7:0], rd_data);
				rd_cnt++;
			end
			seen_ret |= (retired === 1'b1);
			seen_ref |= (refused === 1'b1);
			if (done === 1'b1 || refused === 1'b1) break;
		end
		wr_valid = 1'b0;
		check_bit("op finished", 1'b1, n < 30000);
		check_count("host_faults", 0, host_faults);
	endtask

	task automatic t_erase_pass();
		run_op(OP_ERASE, 10'h005, 1'b1, 1'b0);
		check_bit("failed", 1'b0, failed);
		check_bit("refused", 1'b0, seen_ref);
	endtask

	task automatic t_erase_fail();
		run_op(OP_ERASE, 10'h007, 1'b1, 1'b1);
		check_bit("failed", 1'b1, failed);
		check_bit("retired", 1'b1, seen_ret);
		run_op(OP_PROGRAM, 10'h007, 1'b1, 1'b0);
		check_bit("refused", 1'b1, seen_ref);
	endtask

	task automatic t_program_pages();
		for (int i = 0; i < 2; i++) begin
			run_op(OP_PROGRAM, block_t'(i + 2), i == 0, 1'b0);
			check_bit("failed", 1'b0, failed);
			check_bit("retired", 1'b0, seen_ret);
		end
	endtask

	task automatic t_program_fail();
		run_op(OP_PROGRAM, 10'h009, 1'b0, 1'b1);
		check_bit("retired", 1'b1, seen_ret);
		run_op(OP_ERASE, 10'h009, 1'b1, 1'b0);
		check_bit("refused", 1'b1, seen_ref);
	endtask

	// one status strobe plus a full 512-byte read-back
	task automatic t_program_verify();
		int p0;
		p0 = rd_pulses;
		req_verify = 1'b1;
		run_op(OP_PROGRAM, 10'h00B, 1'b1, 1'b0);
		req_verify = 1'b0;
		check_bit("failed", 1'b0, failed);
		check_count("read strobes", 513, rd_pulses - p0);
	endtask

	task automatic t_read_page();
		run_op(OP_READ, 10'h003, 1'b1, 1'b0);
		check_count("rd_count", 512, rd_cnt);
	endtask

	task automatic t_reset_op();
		run_op(OP_RESET, 10'h000, 1'b1, 1'b0);
		check_bit("refused", 1'b0, seen_ref);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_op = OP_READ;
		req_addr = 24'h000000;
		req_spare = 1'b1;
		req_verify = 1'b0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		fail_op = 1'b0;
		num_errors = 0;
		total_checks = 0;
		rd_pulses = 0;
		repeat (4) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		t_erase_pass();
		t_erase_fail();
		t_program_pages();
		t_program_fail();
		t_program_verify();
		t_read_page();
		t_reset_op();
		test_done();
	end

	// whole run needs about 60k cycles
	initial begin
		#400000;
		num_errors++;
		$display("Error watchdog expected finish seen timeout");
		test_done();
	end
endmodule
